//--- verilog/mcpc_pkg.sv
// Constants for the modem channel and preamble configuration bank.
// Assumes an 8-bit register port with 16-bit addresses on one clock.
package mcpc_pkg;

   // Register port widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // Register addresses
   localparam logic [15:0] MODEM_CONFIG_HIGH_ADDR = 16'hDF0F;
   localparam logic [15:0] MODEM_CONFIG_LOW_ADDR  = 16'hDF10;
   localparam logic [15:0] FREQ_DEV_SETTING_ADDR  = 16'hDF11;

   // Values after reset
   localparam logic [7:0] MODEM_CONFIG_HIGH_RST = 8'h22;
   localparam logic [7:0] MODEM_CONFIG_LOW_RST  = 8'hF8;
   localparam logic [7:0] FREQ_DEV_SETTING_RST  = 8'h47;

   // Writable bits; the others read zero
   localparam logic [7:0] MODEM_CONFIG_HIGH_WMASK = 8'hF3;
   localparam logic [7:0] MODEM_CONFIG_LOW_WMASK  = 8'hFF;
   localparam logic [7:0] FREQ_DEV_SETTING_WMASK  = 8'h77;

   // Field positions
   localparam int FEC_BIT     = 7;
   localparam int PRE_LSB     = 4;
   localparam int SPC_E_LSB   = 0;
   localparam int DEV_E_LSB   = 4;
   localparam int DEV_M_LSB   = 0;

   // Field widths
   localparam int PRE_W   = 3;
   localparam int SPC_E_W = 2;
   localparam int SPC_M_W = 8;
   localparam int DEV_E_W = 3;
   localparam int DEV_M_W = 3;

   // Implied leading ones of the mantissas
   localparam int SPC_IMPLIED = 256;
   localparam int DEV_IMPLIED = 8;

   // Result and input widths
   localparam int PRE_BYTES_W = 5;
   localparam int SPC_W       = 12;
   localparam int DEV_W       = 11;
   localparam int CHANNEL_NUMBER_W      = 8;
   localparam int BASE_W      = 24;
   localparam int LEN_MODE_W  = 2;
   localparam int FREQ_W      = 27;
   // Base word step is four spacing steps
   localparam int BASE_SHIFT  = 2;

endpackage

//--- verilog/mcpc_mant_exp.sv
// Mantissa and exponent expander: (implied + mantissa) shifted by exponent.
// Assumes the caller sizes OUT_W to hold the largest result.
`timescale 1ns/1ps
module mcpc_mant_exp #(
   parameter int MANT_W  = 8,
   parameter int EXP_W   = 2,
   parameter int OUT_W   = 12,
   parameter int IMPLIED = 256
) (
   input  wire logic [MANT_W-1:0] mant_i,
   input  wire logic [EXP_W-1:0]  exp_i,
   output logic      [OUT_W-1:0]  value_o
);

   logic [OUT_W-1:0] full_mant;

   // Restore the implied leading one, then scale
   assign full_mant = OUT_W'(IMPLIED) + OUT_W'(mant_i);
   assign value_o   = full_mant << exp_i;

endmodule

//--- verilog/mcpc_config_bank.sv
// Modem channel, preamble and deviation configuration registers.
// Assumes a same-clock register master and same-clock field consumers.
`timescale 1ns/1ps
module mcpc_config_bank (
   input  wire logic                              core_clk_i,
   input  wire logic                              arst_n_i,
   input  wire logic [mcpc_pkg::ADDR_W-1:0]       addr_i,
   input  wire logic [mcpc_pkg::DATA_W-1:0]       wr_data_i,
   input  wire logic                              wr_en_i,
   input  wire logic                              rd_en_i,
   input  wire logic [mcpc_pkg::BASE_W-1:0]       base_freq_i,
   input  wire logic [mcpc_pkg::CHANNEL_NUMBER_W-1:0]       channel_number_i,
   input  wire logic [mcpc_pkg::LEN_MODE_W-1:0]   length_mode_i,
   output logic      [mcpc_pkg::DATA_W-1:0]       rd_data_o,
   output logic                                   payload_error_correction_enable_o,
   output logic      [mcpc_pkg::PRE_W-1:0]        preamble_code_o,
   output logic      [mcpc_pkg::PRE_BYTES_W-1:0]  preamble_bytes_o,
   output logic      [mcpc_pkg::SPC_M_W-1:0]      channel_spacing_mantissa_o,
   output logic      [mcpc_pkg::SPC_E_W-1:0]      channel_spacing_exponent_o,
   output logic      [mcpc_pkg::DEV_E_W-1:0]      deviation_exponent_o,
   output logic      [mcpc_pkg::DEV_M_W-1:0]      deviation_mantissa_o,
   output logic      [mcpc_pkg::SPC_W-1:0]        channel_spacing_o,
   output logic      [mcpc_pkg::DEV_W-1:0]        deviation_o,
   output logic      [mcpc_pkg::FREQ_W-1:0]       frequency_o,
   output logic                                   fec_mode_conflict_o
);

   // Preamble code to minimum byte count
   function automatic logic [4:0] pre_bytes(input logic [2:0] code);
      case (code)
         3'h0:    pre_bytes = 5'h02;
         3'h1:    pre_bytes = 5'h03;
         3'h2:    pre_bytes = 5'h04;
         3'h3:    pre_bytes = 5'h06;
         3'h4:    pre_bytes = 5'h08;
         3'h5:    pre_bytes = 5'h0C;
         3'h6:    pre_bytes = 5'h10;
         default: pre_bytes = 5'h18;
      endcase
   endfunction

   logic [7:0]                       high_r;
   logic [7:0]                       low_r;
   logic [7:0]                       dev_r;
   logic [7:0]                       high_nxt;
   logic [7:0]                       low_nxt;
   logic [7:0]                       dev_nxt;
   logic [7:0]                       rd_data_r;
   logic [7:0]                       rd_data_nxt;
   logic [mcpc_pkg::PRE_BYTES_W-1:0] pre_bytes_r;
   logic [mcpc_pkg::SPC_W-1:0]       spacing_w;
   logic [mcpc_pkg::SPC_W-1:0]       spacing_r;
   logic [mcpc_pkg::DEV_W-1:0]       deviation_w;
   logic [mcpc_pkg::DEV_W-1:0]       deviation_r;
   logic [mcpc_pkg::FREQ_W-1:0]      freq_nxt;
   logic [mcpc_pkg::FREQ_W-1:0]      freq_r;
   logic                             conflict_r;

   // Write decode with masking of unused bits
   always_comb begin
      high_nxt = high_r;
      low_nxt  = low_r;
      dev_nxt  = dev_r;
      if (wr_en_i) begin
         case (addr_i)
            mcpc_pkg::MODEM_CONFIG_HIGH_ADDR: begin
               high_nxt = wr_data_i & mcpc_pkg::MODEM_CONFIG_HIGH_WMASK;
            end
            mcpc_pkg::MODEM_CONFIG_LOW_ADDR: begin
               low_nxt = wr_data_i & mcpc_pkg::MODEM_CONFIG_LOW_WMASK;
            end
            mcpc_pkg::FREQ_DEV_SETTING_ADDR: begin
               dev_nxt = wr_data_i & mcpc_pkg::FREQ_DEV_SETTING_WMASK;
            end
            default: begin
               high_nxt = high_r;
            end
         endcase
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         high_r <= mcpc_pkg::MODEM_CONFIG_HIGH_RST;
         low_r  <= mcpc_pkg::MODEM_CONFIG_LOW_RST;
         dev_r  <= mcpc_pkg::FREQ_DEV_SETTING_RST;
      end else begin
         high_r <= high_nxt;
         low_r  <= low_nxt;
         dev_r  <= dev_nxt;
      end
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      rd_data_nxt = 8'h00;
      if (rd_en_i) begin
         case (addr_i)
            mcpc_pkg::MODEM_CONFIG_HIGH_ADDR: begin
               rd_data_nxt = high_r;
            end
            mcpc_pkg::MODEM_CONFIG_LOW_ADDR: begin
               rd_data_nxt = low_r;
            end
            mcpc_pkg::FREQ_DEV_SETTING_ADDR: begin
               rd_data_nxt = dev_r;
            end
            default: begin
               rd_data_nxt = 8'h00;
            end
         endcase
      end
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_r <= 8'h00;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // Channel spacing expander
   mcpc_mant_exp #(
      .MANT_W  (mcpc_pkg::SPC_M_W),
      .EXP_W   (mcpc_pkg::SPC_E_W),
      .OUT_W   (mcpc_pkg::SPC_W),
      .IMPLIED (mcpc_pkg::SPC_IMPLIED)
   ) u_spacing (
      .mant_i  (low_r),
      .exp_i   (high_r[mcpc_pkg::SPC_E_LSB +: mcpc_pkg::SPC_E_W]),
      .value_o (spacing_w)
   );

   // Deviation expander
   mcpc_mant_exp #(
      .MANT_W  (mcpc_pkg::DEV_M_W),
      .EXP_W   (mcpc_pkg::DEV_E_W),
      .OUT_W   (mcpc_pkg::DEV_W),
      .IMPLIED (mcpc_pkg::DEV_IMPLIED)
   ) u_deviation (
      .mant_i  (dev_r[mcpc_pkg::DEV_M_LSB +: mcpc_pkg::DEV_M_W]),
      .exp_i   (dev_r[mcpc_pkg::DEV_E_LSB +: mcpc_pkg::DEV_E_W]),
      .value_o (deviation_w)
   );

   // Operating frequency in spacing steps
   assign freq_nxt = (mcpc_pkg::FREQ_W'(base_freq_i) << mcpc_pkg::BASE_SHIFT)
                   + mcpc_pkg::FREQ_W'(spacing_w) * mcpc_pkg::FREQ_W'(channel_number_i);

   // Derived values, registered
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pre_bytes_r <= 5'h00;
         spacing_r   <= 12'h000;
         deviation_r <= 11'h000;
         freq_r      <= 27'h0000000;
      end else begin
         pre_bytes_r <= pre_bytes(high_r[mcpc_pkg::PRE_LSB +: mcpc_pkg::PRE_W]);
         spacing_r   <= spacing_w;
         deviation_r <= deviation_w;
         freq_r      <= freq_nxt;
      end
   end

   // Flags correction used outside fixed length mode
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         conflict_r <= 1'b0;
      end else begin
         conflict_r <= high_r[mcpc_pkg::FEC_BIT] && (length_mode_i != 2'h0);
      end
   end

   // Outputs straight from flops
   assign rd_data_o                         = rd_data_r;
   assign payload_error_correction_enable_o = high_r[mcpc_pkg::FEC_BIT];
   assign preamble_code_o            = high_r[mcpc_pkg::PRE_LSB +: mcpc_pkg::PRE_W];
   assign preamble_bytes_o           = pre_bytes_r;
   assign channel_spacing_mantissa_o = low_r;
   assign channel_spacing_exponent_o = high_r[mcpc_pkg::SPC_E_LSB +: mcpc_pkg::SPC_E_W];
   assign deviation_exponent_o       = dev_r[mcpc_pkg::DEV_E_LSB +: mcpc_pkg::DEV_E_W];
   assign deviation_mantissa_o       = dev_r[mcpc_pkg::DEV_M_LSB +: mcpc_pkg::DEV_M_W];
   assign channel_spacing_o          = spacing_r;
   assign deviation_o                = deviation_r;
   assign frequency_o                = freq_r;
   assign fec_mode_conflict_o        = conflict_r;

   // Independent reference values for the checks
   logic [11:0] chk_spacing;
   logic [10:0] chk_deviation;
   assign chk_spacing   = (12'h100 + {4'h0, low_r}) << high_r[1:0];
   assign chk_deviation = (11'h008 + {8'h00, dev_r[2:0]}) << dev_r[6:4];

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   a_fec_write_enable: assert property (
      wr_en_i && addr_i == 16'hDF0F |=> payload_error_correction_enable_o == $past(wr_data_i[7])
   ) else $error("error correction enable did not follow write");

   a_fec_conflict_flag: assert property (
      high_r[7] && length_mode_i != 2'h0 |=> fec_mode_conflict_o
   ) else $error("correction conflict not flagged");

   // Derived checks start only once reset is seen high, since the flops still reset at release
   a_preamble_decode: assert property (
      arst_n_i |=> preamble_bytes_o == pre_bytes($past(high_r[6:4]))
   ) else $error("preamble byte count wrong");

   a_preamble_max: assert property (
      wr_en_i && addr_i == 16'hDF0F && wr_data_i[6:4] == 3'h7 |=> ##1 preamble_bytes_o == 5'h18
   ) else $error("longest preamble not 24 bytes");

   a_exponent_write: assert property (
      wr_en_i && addr_i == 16'hDF0F |=> channel_spacing_exponent_o == $past(wr_data_i[1:0])
   ) else $error("spacing exponent did not follow write");

   a_spacing_value: assert property (
      arst_n_i |=> channel_spacing_o == $past(chk_spacing)
   ) else $error("channel spacing value wrong");

   a_frequency_sum: assert property (
      arst_n_i |=> frequency_o ==
         $past(27'({base_freq_i, 2'b00}) + 27'(chk_spacing) * 27'(channel_number_i))
   ) else $error("operating frequency wrong");

   a_deviation_value: assert property (
      arst_n_i |=> deviation_o == $past(chk_deviation)
   ) else $error("deviation value wrong");

   a_unused_read_zero: assert property (
      rd_en_i && addr_i == 16'hDF0F |=> rd_data_o[3:2] == 2'h0 ##1 rd_data_o == 8'h00 || $past(rd_en_i)
   ) else $error("unused high bits not zero");

   a_dev_unused_zero: assert property (
      rd_en_i && addr_i == 16'hDF11 |=> rd_data_o[7] == 1'b0 && rd_data_o[3] == 1'b0
   ) else $error("unused deviation bits not zero");

   a_unmapped_zero: assert property (
      rd_en_i && addr_i != 16'hDF0F && addr_i != 16'hDF10 && addr_i != 16'hDF11
      |=> rd_data_o == 8'h00
   ) else $error("unmapped read not zero");

   c_fec_conflict:  cover property (high_r[7] && length_mode_i != 2'h0);
   c_read_low:      cover property (rd_en_i && addr_i == 16'hDF10 ##1 rd_data_o == 8'hF8);
   c_write_then_rd: cover property (wr_en_i && addr_i == 16'hDF11 ##1 rd_en_i);
   c_preamble_max:  cover property (preamble_bytes_o == 5'h18);

endmodule

//--- tb/mcpc_config_bank_test.sv
// Self-checking bench for the modem channel and preamble configuration bank.
// Assumes the bank answers reads one cycle after the strobe and never stalls.
`timescale 1ns/1ps
module mcpc_config_bank_test;
   logic        core_clk = 1'b0;
   logic        arst_n   = 1'b0;
   logic [15:0] addr     = 16'h0000;
   logic [7:0]  wr_data  = 8'h00;
   logic        wr_en    = 1'b0;
   logic        rd_en    = 1'b0;
   logic [23:0] base     = 24'h000000;
   logic [7:0]  channel_number     = 8'h00;
   logic [1:0]  lm       = 2'h0;
   logic [7:0]  rd_data;
   logic        fec;
   logic [2:0]  pre_code;
   logic [4:0]  pre_bytes;
   logic [7:0]  spc_m;
   logic [1:0]  spc_e;
   logic [2:0]  dev_e;
   logic [2:0]  dev_m;
   logic [11:0] spc;
   logic [10:0] dev;
   logic [26:0] freq;
   logic        conflict;
   logic [7:0]  hi = mcpc_pkg::MODEM_CONFIG_HIGH_RST;
   logic [7:0]  lo = mcpc_pkg::MODEM_CONFIG_LOW_RST;
   logic [7:0]  dv = mcpc_pkg::FREQ_DEV_SETTING_RST;
   int          num_errors = 0;
   int          checks = 0;
   int          cycles = 0;

   mcpc_config_bank u_mcpc_config_bank (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .addr_i(addr), .wr_data_i(wr_data),
      .wr_en_i(wr_en), .rd_en_i(rd_en), .base_freq_i(base), .channel_number_i(channel_number),
      .length_mode_i(lm), .rd_data_o(rd_data), .payload_error_correction_enable_o(fec),
      .preamble_code_o(pre_code), .preamble_bytes_o(pre_bytes),
      .channel_spacing_mantissa_o(spc_m), .channel_spacing_exponent_o(spc_e),
      .deviation_exponent_o(dev_e), .deviation_mantissa_o(dev_m),
      .channel_spacing_o(spc), .deviation_o(dev), .frequency_o(freq),
      .fec_mode_conflict_o(conflict));

   // Clock at 40 MHz
   always #12.5 core_clk = ~core_clk;

   // Expected minimum preamble bytes per code
   function automatic logic [4:0] bytes_of(input logic [2:0] c);
      logic [4:0] t [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
      return t[c];
   endfunction

   // Verdict and end of run
   task automatic conclude();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end

   // One-cycle write; the shadow keeps only writable bits of mapped places
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      wr_en   <= 1'b1;
      addr    <= a;
      wr_data <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
      if (a == mcpc_pkg::MODEM_CONFIG_HIGH_ADDR) hi = d & mcpc_pkg::MODEM_CONFIG_HIGH_WMASK;
      if (a == mcpc_pkg::MODEM_CONFIG_LOW_ADDR) lo = d;
      if (a == mcpc_pkg::FREQ_DEV_SETTING_ADDR) dv = d & mcpc_pkg::FREQ_DEV_SETTING_WMASK;
   endtask

   // One-cycle read; data stand for one cycle then fall to zero
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1 check(rd_data, exp);
      @(posedge core_clk);
      #1 check(rd_data, 8'h00);
   endtask

   // Settle derived outputs, then compare every output and read back
   task automatic check_all();
      logic [11:0] s;
      s = 12'((12'h100 + lo) << hi[1:0]);
      repeat (2) @(posedge core_clk);
      #1;
      check(fec, hi[7]);
      check(conflict, hi[7] && lm != 2'h0);
      check(pre_code, hi[6:4]);
      check(pre_bytes, bytes_of(hi[6:4]));
      check(spc_e, hi[1:0]);
      check(spc_m, lo);
      check(spc, s);
      check(freq, 27'({base, 2'b00}) + 27'(s) * 27'(channel_number));
      check(dev_e, dv[6:4]);
      check(dev_m, dv[2:0]);
      check(dev, 11'((11'h008 + dv[2:0]) << dv[6:4]));
      rd(mcpc_pkg::MODEM_CONFIG_HIGH_ADDR, hi);
      rd(mcpc_pkg::MODEM_CONFIG_LOW_ADDR, lo);
      rd(mcpc_pkg::FREQ_DEV_SETTING_ADDR, dv);
      rd(16'hDF0E, 8'h00);
      // Return on a rising edge so the caller's next inputs change at it
      @(posedge core_clk);
   endtask

   // Main sequence: reset values, field corners, then random traffic
   initial begin
      logic [15:0] a;
      void'($urandom(37));
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      check_all();
      // Every preamble code and exponent, unused bits written high
      for (int i = 0; i < 8; i++) begin
         wr(mcpc_pkg::MODEM_CONFIG_HIGH_ADDR, {i[0], i[2:0], 2'b11, i[1:0]});
         check_all();
      end
      // Every deviation exponent with unused bits written high
      for (int i = 0; i < 8; i++) begin
         wr(mcpc_pkg::FREQ_DEV_SETTING_ADDR, {1'b1, i[2:0], 1'b1, 3'(7 - i)});
         check_all();
      end
      // Mantissa extremes with a conflict-causing length mode
      lm   <= 2'h1;
      channel_number <= 8'hFF;
      base <= 24'hFFFFFF;
      wr(mcpc_pkg::MODEM_CONFIG_LOW_ADDR, 8'hFF);
      wr(mcpc_pkg::MODEM_CONFIG_HIGH_ADDR, 8'h83);
      check_all();
      wr(mcpc_pkg::MODEM_CONFIG_LOW_ADDR, 8'h00);
      check_all();
      // Random writes across mapped and unmapped places
      for (int i = 0; i < 80; i++) begin
         case ($urandom_range(3))
            0: a = mcpc_pkg::MODEM_CONFIG_HIGH_ADDR;
            1: a = mcpc_pkg::MODEM_CONFIG_LOW_ADDR;
            2: a = mcpc_pkg::FREQ_DEV_SETTING_ADDR;
            default: a = 16'($urandom);
         endcase
         base <= 24'($urandom);
         channel_number <= 8'($urandom);
         lm   <= 2'($urandom);
         wr(a, 8'($urandom));
         check_all();
      end
      // Second reset in mid-run restores reset values
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      hi = mcpc_pkg::MODEM_CONFIG_HIGH_RST;
      lo = mcpc_pkg::MODEM_CONFIG_LOW_RST;
      dv = mcpc_pkg::FREQ_DEV_SETTING_RST;
      check_all();
      conclude();
   end
endmodule
